/* File: core/rtc_time_alarm_core.sv */
// Time, calendar and alarm core behind a multiplexed host bus.
`timescale 1ns/10ps
`include "rtc_time_alarm_params.svh"
module rtc_time_alarm_core #(
  parameter int OSC_DIV = `OSC_DIV_DEFAULT
) (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic [7:0] ad_in,
  output logic      [7:0] ad_out,
  output logic            ad_oe_n,
  input  wire logic       ale,
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       osc_32k,
  input  wire logic       periodic_event,
  input  wire logic [2:0] ext_event,
  output logic            irq_out,
  output logic            irq_oe_n
);
  localparam int DW = $clog2(OSC_DIV);

  // ==========================================================================
  // Elaboration check
  if (OSC_DIV < 2) begin : g_bad_div
    $error("OSC_DIV must be at least 2");
  end

  // ==========================================================================
  // Helper functions
  function automatic logic [7:0] to_bin(input logic [7:0] v,
                                        input logic bcd);
    to_bin = bcd ? ({4'h0, v[7:4]} * 8'd10) + {4'h0, v[3:0]} : v;
  endfunction : to_bin

  function automatic logic [7:0] from_bin(input logic [7:0] b,
                                          input logic bcd);
    from_bin = bcd ? {4'(b / 8'd10), 4'(b % 8'd10)} : b;
  endfunction : from_bin

  function automatic logic [7:0] hr_to24(input logic [7:0] v,
                                         input logic bcd,
                                         input logic h24);
    logic [7:0] h;
    h = to_bin({1'b0, v[6:0]}, bcd);
    if (h24) begin
      hr_to24 = h;
    end else begin
      hr_to24 = ((h == 8'd12) ? 8'd0 : h) + (v[7] ? 8'd12 : 8'd0);
    end
  endfunction : hr_to24

  function automatic logic [7:0] hr_from24(input logic [7:0] h,
                                           input logic bcd,
                                           input logic h24);
    logic       pm;
    logic [7:0] t;
    logic [7:0] e;
    pm = (h >= 8'd12);
    t = pm ? h - 8'd12 : h;
    if (t == 8'd0) begin
      t = 8'd12;
    end
    e = from_bin(t, bcd);
    hr_from24 = h24 ? from_bin(h, bcd) : {pm, e[6:0]};
  endfunction : hr_from24

  function automatic logic alm_ok(input logic [7:0] a, input logic [7:0] t);
    alm_ok = (a[7:6] == `DONT_CARE) || (a == t);
  endfunction : alm_ok

  // ==========================================================================
  // Pin synchronisers
  logic [12:0] sy1_q;
  logic [12:0] sy2_q;
  logic [12:0] sy3_q;

  // Every bus and oscillator pin passes two flops; the third stage only serves edge detection.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      // Idle levels: strobes high, address strobe low, so no false edge.
      sy1_q <= 13'h1C00;
      sy2_q <= 13'h1C00;
      sy3_q <= 13'h1C00;
    end else begin
      sy1_q <= {cs_n, rd_n, wr_n, ale, osc_32k, ad_in};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end

  wire       cs_s     = ~sy2_q[12];
  wire       rd_fall  = sy3_q[11] & ~sy2_q[11];
  wire       rd_rise  = ~sy3_q[11] & sy2_q[11];
  wire       wr_rise  = ~sy3_q[10] & sy2_q[10];
  wire       ale_fall = sy3_q[9] & ~sy2_q[9];
  wire       osc_rise = ~sy3_q[8] & sy2_q[8];
  wire [7:0] ad_s     = sy2_q[7:0];

  // ==========================================================================
  // Control registers and decode
  logic [7:0] addr_q;
  logic [7:0] a_q;
  logic [7:0] b_q;
  logic [2:0] xen_q;
  logic [7:0] alm_q [3];
  logic [7:0] dalm_q;
  logic [7:0] ram_q [`RAM_BYTES];
  logic [7:0] cnt_q [8];
  logic [7:0] usr_q [8];
  logic [7:0] nxt [8];
  logic [2:0] c_flags_q;
  logic [2:0] held_q;
  logic [2:0] ext_flags_q;
  logic       set_prev_q;
  logic       pending;

  rtc_time_alarm_pkg::bus_state_t bus_q;

  wire       bank1  = a_q[`A_BANK];
  wire       bcd    = ~b_q[`B_FMT];
  wire       h24    = b_q[`B_H24];
  wire       wr_go  = wr_rise & cs_s;
  wire       rd_go  = rd_fall & cs_s;
  wire [7:0] wdata  = ad_s;

  // Time slots: seconds to year, then century in bank 1 only.
  wire       tm_hit = addr_q == `OFF_SEC || addr_q == `OFF_MIN
                   || addr_q == `OFF_HR || addr_q == `OFF_WDAY
                   || addr_q == `OFF_DATE || addr_q == `OFF_MON
                   || addr_q == `OFF_YEAR
                   || (bank1 && addr_q == `OFF_CENT);
  wire [2:0] tm_idx = addr_q == `OFF_SEC  ? 3'h0 :
                      addr_q == `OFF_MIN  ? 3'h1 :
                      addr_q == `OFF_HR   ? 3'h2 :
                      addr_q == `OFF_WDAY ? 3'h3 :
                      addr_q == `OFF_DATE ? 3'h4 :
                      addr_q == `OFF_MON  ? 3'h5 :
                      addr_q == `OFF_YEAR ? 3'h6 : 3'h7;
  wire       al_hit = addr_q == `OFF_SEC_AL || addr_q == `OFF_MIN_AL
                   || addr_q == `OFF_HR_AL;
  wire [1:0] al_idx = addr_q[2:1];
  wire       dal_hit = bank1 && addr_q == `OFF_DALM;
  wire       a_sel  = addr_q == `OFF_CTL_A;
  wire       b_sel  = addr_q == `OFF_CTL_B;
  wire       c_sel  = addr_q == `OFF_CTL_C;
  wire       d_sel  = addr_q == `OFF_CTL_D;
  wire       xf_sel = bank1 && addr_q == `OFF_XFLAG;
  wire       xe_sel = bank1 && addr_q == `OFF_XEN;
  wire       ram_hit = addr_q >= `RAM_BASE && !addr_q[7]
                    && (!bank1 || addr_q < `RAM_B1_END);
  wire [6:0] ram_idx = 7'(addr_q - `RAM_BASE);
  wire       tm_wr  = wr_go && tm_hit;
  wire       ext_wr = wr_go && xf_sel;
  wire       reload = set_prev_q & ~b_q[`B_SET];

  // Read data selection; unmapped locations read zero.
  wire [7:0] rdata = tm_hit  ? usr_q[tm_idx] :
                     al_hit  ? alm_q[al_idx] :
                     dal_hit ? dalm_q :
                     a_sel   ? {1'b0, a_q[6:0]} :
                     b_sel   ? b_q :
                     c_sel   ? {pending, c_flags_q, 4'h0} :
                     d_sel   ? `D_VALID :
                     xf_sel  ? {5'h00, ext_flags_q} :
                     xe_sel  ? {5'h00, xen_q} :
                     ram_hit ? ram_q[ram_idx] : 8'h00;

  // Address latch on the falling strobe, even without chip select.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      addr_q <= 8'h00;
    end else if (ale_fall) begin
      addr_q <= ad_s;
    end
  end

  // Control registers are writable at any time, even mid-update.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      a_q        <= `A_RST;
      b_q        <= `B_RST;
      xen_q      <= 3'h0;
      dalm_q     <= `ONE_RST;
      set_prev_q <= 1'b0;
    end else begin
      set_prev_q <= b_q[`B_SET];
      if (wr_go && a_sel) a_q <= {1'b0, wdata[6:0]};
      if (wr_go && b_sel) b_q <= wdata;
      if (wr_go && xe_sel) xen_q <= wdata[2:0];
      if (wr_go && dal_hit) dalm_q <= wdata;
    end
  end

  // Alarm bytes have a single copy; they never advance.
  for (genvar i = 0; i < 3; i++) begin : g_alm
    always_ff @(posedge clock) begin
      if (!nrst) begin
        alm_q[i] <= `ZERO_RST;
      end else if (wr_go && al_hit && al_idx == 2'(i)) begin
        alm_q[i] <= wdata;
      end
    end
  end

  // User RAM holds data only, so it carries no reset.
  always_ff @(posedge clock) begin
    if (wr_go && ram_hit) begin
      ram_q[ram_idx] <= wdata;
    end
  end

  // ==========================================================================
  // Divider chain and one-second tick
  logic [DW-1:0] div_q;
  wire dv_run  = a_q[`A_DV_HI:`A_DV_LO] == `DV_RUN;
  wire dv_hold = a_q[`A_DV_HI:`A_DV_LO] == `DV_HOLD;
  wire tick    = dv_run && osc_rise && div_q == DW'(OSC_DIV - 1);

  // A held chain restarts a full second when released.
  always_ff @(posedge clock) begin
    if (!nrst || dv_hold) begin
      div_q <= '0;
    end else if (dv_run && osc_rise) begin
      div_q <= tick ? '0 : div_q + 1'b1;
    end
  end

  // ==========================================================================
  // Calendar advance, worked in binary and returned in the active format
  always_comb begin
    logic [7:0] s, m, h, w, d, mo, y, c, dim;
    s  = to_bin(cnt_q[0], bcd);
    m  = to_bin(cnt_q[1], bcd);
    h  = hr_to24(cnt_q[2], bcd, h24);
    w  = to_bin(cnt_q[3], bcd);
    d  = to_bin(cnt_q[4], bcd);
    mo = to_bin(cnt_q[5], bcd);
    y  = to_bin(cnt_q[6], bcd);
    c  = to_bin(cnt_q[7], bcd);
    dim = 8'd31;
    // Plain four-year leap rule; correct through the year 2099.
    case (mo)
      8'd2:    dim = (y[1:0] == 2'h0) ? 8'd29 : 8'd28;
      8'd4, 8'd6, 8'd9, 8'd11: dim = 8'd30;
      default: dim = 8'd31;
    endcase
    s = s + 8'd1;
    if (s >= 8'd60) begin
      s = 8'd0;
      m = m + 8'd1;
    end
    if (m >= 8'd60) begin
      m = 8'd0;
      h = h + 8'd1;
    end
    if (h >= 8'd24) begin
      h = 8'd0;
      w = w + 8'd1;
      d = d + 8'd1;
    end
    if (w > 8'd7) w = 8'd1;
    if (d > dim) begin
      d  = 8'd1;
      mo = mo + 8'd1;
    end
    if (mo > 8'd12) begin
      mo = 8'd1;
      y  = y + 8'd1;
    end
    if (y > 8'd99) begin
      y = 8'd0;
      c = c + 8'd1;
    end
    if (c > 8'd99) c = 8'd0;
    nxt[0] = from_bin(s, bcd);
    nxt[1] = from_bin(m, bcd);
    nxt[2] = hr_from24(h, bcd, h24);
    nxt[3] = from_bin(w, bcd);
    nxt[4] = from_bin(d, bcd);
    nxt[5] = from_bin(mo, bcd);
    nxt[6] = from_bin(y, bcd);
    nxt[7] = from_bin(c, bcd);
  end

  // Internal counters keep running under update inhibit; the user copy
  // freezes so a multi-byte read stays coherent; on release the counters reload from it.
  for (genvar i = 0; i < 8; i++) begin : g_time
    wire       hit_i = tm_wr && tm_idx == 3'(i);
    wire [7:0] wd_i  = (i == 0) ? {1'b0, wdata[6:0]} : wdata;
    always_ff @(posedge clock) begin
      if (!nrst) begin
        cnt_q[i] <= (i >= 3 && i <= 5) ? `ONE_RST : `ZERO_RST;
        usr_q[i] <= (i >= 3 && i <= 5) ? `ONE_RST : `ZERO_RST;
      end else begin
        if (hit_i) usr_q[i] <= wd_i;
        else if (tick && !b_q[`B_SET]) usr_q[i] <= nxt[i];
        if (hit_i && !b_q[`B_SET]) cnt_q[i] <= wd_i;
        else if (reload) cnt_q[i] <= usr_q[i];
        else if (tick) cnt_q[i] <= nxt[i];
      end
    end
  end

  // ==========================================================================
  // Interrupt flags and request
  wire       alarm_hit = alm_ok(alm_q[0], nxt[0]) && alm_ok(alm_q[1], nxt[1])
                      && alm_ok(alm_q[2], nxt[2]);
  wire [2:0] ev_c   = {periodic_event, tick && alarm_hit, tick};
  wire [2:0] en_c   = {b_q[`B_PIE], b_q[`B_AIE], b_q[`B_UIE]};
  wire       c_busy = c_sel && (rd_go || bus_q == rtc_time_alarm_pkg::BUS_READ);
  wire       c_end  = c_busy && rd_rise;

  assign pending = |(c_flags_q & en_c) || |(ext_flags_q & xen_q);

  // Flags stay frozen through a read of C; what arrives meanwhile waits.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      c_flags_q   <= 3'h0;
      held_q      <= 3'h0;
      ext_flags_q <= 3'h0;
    end else begin
      if (c_end) c_flags_q <= held_q | ev_c;
      else if (!c_busy) c_flags_q <= c_flags_q | ev_c;
      held_q <= (c_busy && !c_end) ? held_q | ev_c : 3'h0;
      ext_flags_q <= (ext_wr ? ext_flags_q & wdata[2:0] : ext_flags_q)
                     | ext_event;
    end
  end

  // Open-drain request: the enable is low while the pin is pulled down.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      irq_out  <= 1'b0;
      irq_oe_n <= 1'b1;
    end else begin
      irq_out  <= 1'b0;
      irq_oe_n <= ~pending;
    end
  end

  // ==========================================================================
  // Host read drive
  always_ff @(posedge clock) begin
    if (!nrst) begin
      bus_q   <= rtc_time_alarm_pkg::BUS_IDLE;
      ad_out  <= 8'h00;
      ad_oe_n <= 1'b1;
    end else begin
      case (bus_q)
        rtc_time_alarm_pkg::BUS_IDLE: begin
          if (rd_go) begin
            bus_q   <= rtc_time_alarm_pkg::BUS_READ;
            ad_out  <= rdata;
            ad_oe_n <= 1'b0;
          end
        end
        rtc_time_alarm_pkg::BUS_READ: begin
          if (rd_rise) begin
            bus_q   <= rtc_time_alarm_pkg::BUS_IDLE;
            ad_oe_n <= 1'b1;
          end
        end
        default: begin
          bus_q   <= rtc_time_alarm_pkg::BUS_IDLE;
          ad_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence c_read_done;
    c_busy ##0 rd_rise;
  endsequence

  irq_on_a: assert property (pending |=> !irq_oe_n)
    else $error("request not driven while a source is pending");
  irq_off_a: assert property (!pending |=> irq_oe_n)
    else $error("request driven with no pending source");
  enable_now_a: assert property ($rose(b_q[`B_AIE]) && c_flags_q[`FL_AF]
    |=> !irq_oe_n)
    else $error("late enable of a set flag did not raise request");
  sum_read_a: assert property (rd_go && c_sel && bus_q[0]
    |=> ad_out[7] == $past(pending))
    else $error("summary flag does not match request state");
  c_clear_a: assert property (c_read_done
    |=> c_flags_q == $past(held_q | ev_c))
    else $error("flags not cleared or held events lost after read");
  ext_hold_a: assert property (!ext_wr
    |=> (ext_flags_q & $past(ext_flags_q)) == $past(ext_flags_q))
    else $error("extended flag cleared without a write");
  alarm_dc_a: assert property (tick && !c_busy
    && alm_q[0][7:6] == `DONT_CARE && alm_q[1][7:6] == `DONT_CARE
    && alm_q[2][7:6] == `DONT_CARE |=> c_flags_q[`FL_AF])
    else $error("all don't-care alarm did not fire");
  sec_step_a: assert property (tick && !tm_wr && !reload
    && to_bin(cnt_q[0], bcd) < 8'd59 |=> to_bin(cnt_q[0], bcd)
    == $past(to_bin(cnt_q[0], bcd)) + 8'd1)
    else $error("seconds did not advance by one");
  freeze_a: assert property (tick && b_q[`B_SET] && !tm_wr
    |=> $stable(usr_q[0]))
    else $error("user copy changed under update inhibit");
  hr12_a: assert property (tick && !h24 && !tm_wr && !reload
    |=> cnt_q[2][6:0] != 7'h00)
    else $error("12-hour count produced hour zero");
endmodule : rtc_time_alarm_core

/* File: core/rtc_time_alarm_params.svh */
// Register offsets, bit positions, reset values and counts of the clock core.
`ifndef RTC_TIME_ALARM_PARAMS_SVH
`define RTC_TIME_ALARM_PARAMS_SVH
`define OFF_SEC         8'h00
`define OFF_SEC_AL      8'h01
`define OFF_MIN         8'h02
`define OFF_MIN_AL      8'h03
`define OFF_HR          8'h04
`define OFF_HR_AL       8'h05
`define OFF_WDAY        8'h06
`define OFF_DATE        8'h07
`define OFF_MON         8'h08
`define OFF_YEAR        8'h09
`define OFF_CTL_A       8'h0A
`define OFF_CTL_B       8'h0B
`define OFF_CTL_C       8'h0C
`define OFF_CTL_D       8'h0D
`define OFF_CENT        8'h48
`define OFF_DALM        8'h49
`define OFF_XFLAG       8'h4A
`define OFF_XEN         8'h4B
`define RAM_BASE        8'h0E
`define RAM_B1_END      8'h40
`define RAM_BYTES       114
`define A_BANK          4
`define A_DV_HI         6
`define A_DV_LO         5
`define DV_RUN          2'h1
`define DV_HOLD         2'h3
`define B_SET           7
`define B_PIE           6
`define B_AIE           5
`define B_UIE           4
`define B_FMT           2
`define B_H24           1
`define FL_PF           2
`define FL_AF           1
`define FL_UF           0
`define D_VALID         8'h80
`define A_RST           8'h20
`define B_RST           8'h02
`define ZERO_RST        8'h00
`define ONE_RST         8'h01
`define DONT_CARE       2'h3
`define OSC_DIV_DEFAULT 32768
`endif

/* File: core/rtc_time_alarm_pkg.sv */
// Types shared by the clock core.
package rtc_time_alarm_pkg;
  // Host bus phase, one-hot.
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h1,
    BUS_READ = 2'h2
  } bus_state_t;
endpackage : rtc_time_alarm_pkg

/* File: verif/rtc_host_model.sv */
// Host processor model that drives the multiplexed address/data bus.
`timescale 1ns/10ps
module rtc_host_model (
  input  wire logic       clock,
  input  wire logic [7:0] ad_out,
  input  wire logic       ad_oe_n,
  output logic      [7:0] ad_in,
  output logic            ale,
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n
);
  logic       drv_en;
  logic [7:0] drv_val;
  logic [7:0] last_q = 8'h00;

  // ==========
  // Bus level
  // A released bus shows the inverse of its last level, so a stale value
  // can never pass for fresh read data.
  assign ad_in = (ad_oe_n === 1'b0) ? ad_out : (drv_en ? drv_val : ~last_q);
  // Only a driven level is remembered, so the released bus stays put.
  always @(posedge clock) begin
    if (ad_oe_n === 1'b0 || drv_en) begin
      last_q <= ad_in;
    end
  end

  // Idle pins from time zero.
  initial begin
    ale = 1'b0;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    drv_en = 1'b0;
    drv_val = 8'h00;
  end

  // ==========
  // Bus cycles
  // Every pin level lasts at least three clocks so the synchronisers see it, but chip select stays high only two after a read.
  task automatic addr_phase(input logic [7:0] a);
    @(negedge clock);
    drv_en = 1'b1;
    drv_val = a;
    ale = 1'b1;
    cs_n = 1'b0;
    repeat (3) @(negedge clock);
    ale = 1'b0;
    repeat (3) @(negedge clock);
  endtask : addr_phase

  // Data is held three clocks past the write strobe's rise.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_phase(a);
    drv_val = d;
    wr_n = 1'b0;
    repeat (4) @(negedge clock);
    wr_n = 1'b1;
    repeat (3) @(negedge clock);
    drv_en = 1'b0;
    cs_n = 1'b1;
    repeat (3) @(negedge clock);
  endtask : wr

  // The strobe is held until the device drives the bus, bounded.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    addr_phase(a);
    drv_en = 1'b0;
    rd_n = 1'b0;
    n = 0;
    while (ad_oe_n !== 1'b0 && n < 8) begin
      @(negedge clock);
      n++;
    end
    d = (ad_oe_n === 1'b0) ? ad_out : 8'hXX;
    rd_n = 1'b1;
    n = 0;
    while (ad_oe_n !== 1'b1 && n < 8) begin
      @(negedge clock);
      n++;
    end
    cs_n = 1'b1;
    @(negedge clock);
  endtask : rd
endmodule : rtc_host_model

/* File: verif/rtc_time_alarm_core_test.sv */
// Self-checking bench for the clock core behind its host bus.
`timescale 1ns/10ps
`include "rtc_time_alarm_params.svh"
module rtc_time_alarm_core_test;
  localparam int DIV = 4;
  localparam int LIMIT = 30000;
  logic       clock;
  logic       nrst;
  logic       osc_32k;
  logic       periodic_event;
  logic [2:0] ext_event;
  logic [7:0] ad_in;
  logic [7:0] ad_out;
  logic       ad_oe_n;
  logic       ale;
  logic       cs_n;
  logic       rd_n;
  logic       wr_n;
  logic       irq_out;
  logic       irq_oe_n;
  int         error_cnt = 0;
  int         check_count = 0;
  int         cyc = 0;
  logic [7:0] v;
  // Format rows: control with inhibit, max sec/min, start hour, next hour.
  logic [7:0] fmt_tab [4][4] = '{'{8'h86, 8'h3B, 8'h17, 8'h00},
    '{8'h84, 8'h3B, 8'h8B, 8'h0C}, '{8'h80, 8'h59, 8'h11, 8'h92},
    '{8'h80, 8'h59, 8'h92, 8'h81}};
  // Alarm rows: bytes at offsets 0 to 5, then whether the alarm fires.
  logic [7:0] al_tab [6][7] = '{
    '{8'h30, 8'h31, 8'h20, 8'h20, 8'h10, 8'h10, 8'h01},
    '{8'h30, 8'h32, 8'h20, 8'h20, 8'h10, 8'h10, 8'h00},
    '{8'h59, 8'h00, 8'h59, 8'h00, 8'h05, 8'hFF, 8'h01},
    '{8'h59, 8'h00, 8'h33, 8'hC5, 8'h07, 8'hC0, 8'h01},
    '{8'h03, 8'hFF, 8'h02, 8'hFF, 8'h01, 8'hFF, 8'h01},
    '{8'h59, 8'h00, 8'h58, 8'h00, 8'h05, 8'hFF, 8'h00}};

  rtc_time_alarm_core #(.OSC_DIV(DIV)) uut (.clock(clock), .nrst(nrst),
    .ad_in(ad_in), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .ale(ale),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .osc_32k(osc_32k),
    .periodic_event(periodic_event), .ext_event(ext_event),
    .irq_out(irq_out), .irq_oe_n(irq_oe_n));
  rtc_host_model host (.clock(clock), .ad_out(ad_out), .ad_oe_n(ad_oe_n),
    .ad_in(ad_in), .ale(ale), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n));

  // ==========
  // Clock and guard
  initial clock = 1'b0;
  always #25 clock = ~clock;
  // A hung bus cycle would otherwise stall the run forever.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      complete_run();
    end
  end

  // ==========
  // Helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    check(d, exp);
  endtask : rc
  // The request pin lags its cause by a couple of clocks.
  task automatic irq_is(input logic e);
    repeat (4) @(negedge clock);
    check({7'h00, irq_oe_n}, {7'h00, e});
    check({7'h00, irq_out}, 8'h00);
  endtask : irq_is
  // One second of oscillator edges, then room for sync and update.
  task automatic sec();
    repeat (DIV) begin
      repeat (4) @(negedge clock);
      osc_32k = 1'b1;
      repeat (4) @(negedge clock);
      osc_32k = 1'b0;
    end
    repeat (6) @(negedge clock);
  endtask : sec
  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  // ==========
  // Main sequence
  initial begin
    nrst = 1'b0;
    osc_32k = 1'b0;
    periodic_event = 1'b0;
    ext_event = 3'h0;
    repeat (12) @(negedge clock);
    nrst = 1'b1;
    rc(`OFF_CTL_A, `A_RST);
    rc(`OFF_CTL_B, `B_RST);
    rc(`OFF_CTL_D, `D_VALID);
    rc(`OFF_WDAY, 8'h01);
    done("reset");
    // Month end carry, plain year then leap year.
    for (int i = 0; i < 2; i++) begin
      host.wr(`OFF_CTL_B, 8'h82);
      host.wr(`OFF_SEC, 8'hD9);
      host.wr(`OFF_MIN, 8'h59);
      host.wr(`OFF_HR, 8'h23);
      host.wr(`OFF_WDAY, 8'h07);
      host.wr(`OFF_DATE, 8'h28);
      host.wr(`OFF_MON, 8'h02);
      host.wr(`OFF_YEAR, i ? 8'h04 : 8'h01);
      rc(`OFF_SEC, 8'h59);
      host.wr(`OFF_CTL_B, 8'h02);
      sec();
      rc(`OFF_SEC, 8'h00);
      rc(`OFF_HR, 8'h00);
      rc(`OFF_WDAY, 8'h01);
      rc(`OFF_DATE, i ? 8'h29 : 8'h01);
      rc(`OFF_MON, i ? 8'h02 : 8'h03);
    end
    done("calendar");
    // Binary 24-hour, binary 12-hour and BCD 12-hour formats; all ten bytes are rewritten after a format change.
    foreach (fmt_tab[i]) begin
      host.wr(`OFF_CTL_B, fmt_tab[i][0]);
      for (int k = 0; k < 10; k++) begin
        host.wr(8'(k), k < 4 ? fmt_tab[i][1] :
          (k < 6 ? fmt_tab[i][2] : 8'h01));
      end
      host.wr(`OFF_CTL_B, fmt_tab[i][0] & 8'h7F);
      sec();
      rc(`OFF_MIN, 8'h00);
      rc(`OFF_HR, fmt_tab[i][3]);
    end
    done("formats");
    // Exact and don't-care alarms, with the flag cleared by reading.
    foreach (al_tab[i]) begin
      host.wr(`OFF_CTL_B, 8'h82);
      for (int k = 0; k < 10; k++) begin
        host.wr(8'(k), k < 6 ? al_tab[i][k] : 8'h01);
      end
      host.wr(`OFF_CTL_B, 8'h22);
      host.rd(`OFF_CTL_C, v);
      sec();
      irq_is(~al_tab[i][6][0]);
      host.wr(`OFF_CTL_B, 8'h02);
      irq_is(1'b1);
      host.wr(`OFF_CTL_B, 8'h22);
      irq_is(~al_tab[i][6][0]);
      rc(`OFF_CTL_C, al_tab[i][6][0] ? 8'hB0 : 8'h10);
      rc(`OFF_CTL_C, 8'h00);
      irq_is(1'b1);
    end
    done("alarms");
    // Extended sources: flags stick, enables gate the request.
    host.wr(`OFF_CTL_A, 8'hB0);
    rc(`OFF_CTL_A, 8'h30);
    host.wr(`OFF_XEN, 8'h00);
    host.wr(`OFF_CTL_B, 8'h02);
    @(negedge clock);
    ext_event = 3'h5;
    @(negedge clock);
    ext_event = 3'h0;
    irq_is(1'b1);
    rc(`OFF_XFLAG, 8'h05);
    rc(`OFF_XFLAG, 8'h05);
    host.wr(`OFF_XEN, 8'h01);
    irq_is(1'b0);
    rc(`OFF_CTL_C, 8'h80);
    host.wr(`OFF_XFLAG, 8'h04);
    irq_is(1'b1);
    host.wr(`OFF_XEN, 8'h04);
    irq_is(1'b0);
    host.wr(`OFF_XFLAG, 8'h00);
    irq_is(1'b1);
    host.wr(`OFF_CTL_B, 8'h42);
    @(negedge clock);
    periodic_event = 1'b1;
    @(negedge clock);
    periodic_event = 1'b0;
    irq_is(1'b0);
    rc(`OFF_CTL_C, 8'hC0);
    irq_is(1'b1);
    done("interrupts");
    // Bank 1 only locations against bank 0 user RAM at the same offsets.
    host.wr(`OFF_CENT, 8'h19);
    host.wr(`OFF_DALM, 8'h15);
    host.wr(8'h50, 8'hAA);
    rc(`OFF_DALM, 8'h15);
    rc(8'h50, 8'h00);
    rc(`OFF_CTL_B, 8'h42);
    host.wr(`OFF_CTL_A, 8'h20);
    host.wr(`OFF_CENT, 8'h77);
    host.wr(8'h7F, 8'h5A);
    rc(`OFF_CENT, 8'h77);
    rc(8'h7F, 8'h5A);
    host.wr(`OFF_CTL_A, 8'h30);
    rc(`OFF_CENT, 8'h19);
    done("banks");
    // Held chain, frozen user copy, then update interrupt enabled.
    host.wr(`OFF_CTL_A, 8'h60);
    sec();
    rc(`OFF_SEC, 8'h00);
    host.wr(`OFF_CTL_A, 8'h20);
    host.wr(`OFF_CTL_B, 8'h82);
    sec();
    rc(`OFF_SEC, 8'h00);
    host.wr(`OFF_CTL_B, 8'h12);
    sec();
    rc(`OFF_SEC, 8'h01);
    irq_is(1'b0);
    rc(`OFF_CTL_C, 8'h90);
    irq_is(1'b1);
    done("chain");
    complete_run();
  end
endmodule : rtc_time_alarm_core_test
